//--- common/power_seq_cfg.svh
/*
  Timing counts and encodings for the module power sequencer.
  Assumes a 100 MHz system clock; included by the package and the sequencer.
*/
`ifndef POWER_SEQ_CFG_SVH
`define POWER_SEQ_CFG_SVH
`define CLK_PERIOD_NS       10
`define PWRON_LOW_NS        1000
`define PWRON_LOW_CYC       ((`PWRON_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_LOW_NS        1000
`define RESET_LOW_CYC       ((`RESET_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CORE_RESET_NS       200
`define CORE_RESET_CYC      ((`CORE_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define NUM_IFACES          4
`define CNT_W               16
`define HALT_CFUN_VALUE     8'h7F
`endif

//--- common/power_seq_pkg.sv
/*
  Types for the module power sequencer.
  Assumes power_seq_cfg.svh is on the include path.
*/
`include "power_seq_cfg.svh"
package power_seq_pkg;
  typedef enum logic [3:0] {
    ST_NOT_POWERED = 4'h0,
    ST_RESET_HOLD  = 4'h1,
    ST_CORE_RESET  = 4'h2,
    ST_CONFIG      = 4'h3,
    ST_READY       = 4'h4,
    ST_SAVE        = 4'h5,
    ST_DETACH      = 4'h6,
    ST_POWER_OFF   = 4'h7,
    ST_HALT        = 4'h8
  } seq_state_t;

  typedef enum logic [1:0] {
    CMD_POWER_OFF = 2'h0,
    CMD_SW_RESET  = 2'h1,
    CMD_HALT      = 2'h2
  } cmd_kind_t;

  typedef struct packed {
    logic      valid;
    cmd_kind_t kind;
  } host_cmd_t;

  typedef struct packed {
    logic save_req;
    logic detach_req;
    logic reply_ok;
  } nv_net_t;
endpackage

//--- hw/low_pulse_filter.sv
/*
  Qualifies an active-low input that must stay low for a minimum number of cycles.
  Assumes the input is already synchronous to sys_clk.
*/
module low_pulse_filter #(
  parameter int MIN_CYC = 100
) (
  input  wire logic sys_clk,
  input  wire logic nrst,
  input  wire logic level_n,
  output logic      qualified
);
  localparam int W = $clog2(MIN_CYC + 1);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic         q_reg;
  logic         q_next;

  always_comb begin
    cnt_next = cnt_reg;
    q_next   = 1'b0;
    if (level_n) begin
      cnt_next = '0;
    end else if (cnt_reg != W'(MIN_CYC)) begin
      cnt_next = cnt_reg + W'(1);
    end
    // One pulse per low episode, when the hold time is reached
    if (!level_n && cnt_reg == W'(MIN_CYC - 1)) begin
      q_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= '0;
      q_reg   <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      q_reg   <= q_next;
    end
  end

  assign qualified = q_reg;
endmodule

//--- hw/module_power_sequencer.sv
/*
  Switch-on, switch-off and reset sequencer of a cellular modem module.
  Assumes one 100 MHz clock, synchronous inputs, supply-good from an external detector.
*/
// How it works
// - Supply rising from below threshold switches on
// - Reset held low at rise defers start
// - Power-on request ignored while supply ramps
// - Power-off wakes on request, reset, alarm
// - Pull-ups on; RTC supply follows supply-valid
// - Digital pins tri-stated until IO supply
// - Core reset, ordered config, then ready
// - Greeting only with fixed baud rate
// - Power-off command saves, detaches, OK, off
// - Mini-card power-off command reboots instead
// - Supply loss shuts down without save
// - Halt command saves, detaches, replies OK
// - Long reset low: immediate reset/shutdown
// - Temperature danger shuts down if enabled
// - Software reset saves and detaches first
// - Pull-ups on every external reset input
`include "power_seq_cfg.svh"
module module_power_sequencer #(
  parameter int PWRON_MIN_CYC = `PWRON_LOW_CYC,
  parameter int RESET_MIN_CYC = `RESET_LOW_CYC,
  parameter int NUM_IF        = `NUM_IFACES
) (
  input  wire logic                      sys_clk,
  input  wire logic                      nrst,
  input  wire logic                      supply_valid,
  input  wire logic                      supply_low_start,
  input  wire logic                      power_on_request_n,
  input  wire logic                      ext_reset_n,
  input  wire logic                      rtc_alarm,
  input  wire logic                      mini_card,
  input  wire logic                      fixed_baud,
  input  wire logic                      greeting_en,
  input  wire logic                      temperature_supervisor_cmd,
  input  wire logic                      temp_danger,
  input  wire power_seq_pkg::host_cmd_t  host_cmd,
  input  wire logic                      nv_done,
  input  wire logic                      detach_done,
  input  wire logic [NUM_IF-1:0]         iface_done,
  output power_seq_pkg::nv_net_t         nv_net,
  output logic                           pullup_en,
  output logic                           rtc_supply_output,
  output logic                           io_supply_en,
  output logic                           pins_oe_allow,
  output logic                           core_reset_n,
  output logic [NUM_IF-1:0]              iface_cfg_en,
  output logic                           ready,
  output logic                           greeting_send
);
  import power_seq_pkg::*;

  // ----------------------------------------------------------------
  // Qualified low pulses
  // ----------------------------------------------------------------
  logic pwron_q;
  logic reset_q;

  low_pulse_filter #(.MIN_CYC(PWRON_MIN_CYC)) u_pwron_filt (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .level_n   (power_on_request_n),
    .qualified (pwron_q)
  );

  low_pulse_filter #(.MIN_CYC(RESET_MIN_CYC)) u_reset_filt (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .level_n   (ext_reset_n),
    .qualified (reset_q)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  localparam int CW = `CNT_W;
  localparam int IW = (NUM_IF > 1) ? $clog2(NUM_IF) : 1;

  seq_state_t      state_reg;
  seq_state_t      state_next;
  logic [CW-1:0]   cnt_reg;
  logic [CW-1:0]   cnt_next;
  logic [IW-1:0]   if_idx_reg;
  logic [IW-1:0]   if_idx_next;
  logic [NUM_IF-1:0] cfg_reg;
  logic [NUM_IF-1:0] cfg_next;
  cmd_kind_t       kind_reg;
  cmd_kind_t       kind_next;
  logic            armed_reg;
  logic            armed_next;
  logic            ok_reg;
  logic            ok_next;
  logic            greet_reg;
  logic            greet_next;
  logic            temp_en_reg;
  logic            temp_en_next;

  always_comb begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    if_idx_next  = if_idx_reg;
    cfg_next     = cfg_reg;
    kind_next    = kind_reg;
    armed_next   = armed_reg;
    ok_next      = 1'b0;
    greet_next   = 1'b0;
    temp_en_next = temperature_supervisor_cmd;
    case (state_reg)
      ST_NOT_POWERED: begin
        // Power-on request level is not looked at here
        if (supply_valid && armed_reg) begin
          armed_next = 1'b0;
          state_next = ST_RESET_HOLD;
        end
      end
      ST_RESET_HOLD: begin
        if (ext_reset_n) begin
          cnt_next   = '0;
          state_next = ST_CORE_RESET;
        end
      end
      ST_CORE_RESET: begin
        cnt_next = cnt_reg + CW'(1);
        if (cnt_reg == CW'(`CORE_RESET_CYC - 1)) begin
          if_idx_next = '0;
          cfg_next    = '0;
          state_next  = ST_CONFIG;
        end
      end
      ST_CONFIG: begin
        // Interfaces come up one at a time, in index order
        cfg_next[if_idx_reg] = 1'b1;
        if (iface_done[if_idx_reg]) begin
          if (if_idx_reg == IW'(NUM_IF - 1)) begin
            state_next = ST_READY;
            greet_next = greeting_en && fixed_baud;
          end else begin
            if_idx_next = if_idx_reg + IW'(1);
          end
        end
      end
      ST_READY: begin
        if (host_cmd.valid) begin
          kind_next  = host_cmd.kind;
          state_next = ST_SAVE;
        end
      end
      ST_SAVE: begin
        if (nv_done) begin
          state_next = ST_DETACH;
        end
      end
      ST_DETACH: begin
        if (detach_done) begin
          ok_next = 1'b1;
          if (kind_reg == CMD_HALT) begin
            state_next = ST_HALT;
          end else if (kind_reg == CMD_SW_RESET || mini_card) begin
            cnt_next   = '0;
            state_next = ST_CORE_RESET;
          end else begin
            state_next = ST_POWER_OFF;
          end
        end
      end
      ST_POWER_OFF: begin
        if (pwron_q || reset_q || rtc_alarm) begin
          cnt_next   = '0;
          state_next = ST_CORE_RESET;
        end
      end
      ST_HALT: begin
        state_next = ST_HALT;
      end
      default: begin
        state_next = ST_NOT_POWERED;
      end
    endcase
    // Supply must first fall below the start threshold to re-arm; re-arm wins over use
    if (supply_low_start) begin
      armed_next = 1'b1;
    end
    // Overriding shutdowns and mini-card resets: no save, no detach
    if (state_reg != ST_NOT_POWERED && state_reg != ST_RESET_HOLD) begin
      if (temp_en_reg && temp_danger) begin
        state_next = ST_POWER_OFF;
      end
      if (reset_q && state_reg != ST_POWER_OFF) begin
        cnt_next   = '0;
        state_next = mini_card ? ST_CORE_RESET : ST_POWER_OFF;
      end
    end
    if (!supply_valid) begin
      state_next = ST_NOT_POWERED;
    end
    if (state_next != ST_CONFIG) begin
      cfg_next = (state_next == ST_READY) ? cfg_reg : '0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg   <= ST_NOT_POWERED;
      cnt_reg     <= '0;
      if_idx_reg  <= '0;
      cfg_reg     <= '0;
      kind_reg    <= CMD_POWER_OFF;
      armed_reg   <= 1'b1;
      ok_reg      <= 1'b0;
      greet_reg   <= 1'b0;
      temp_en_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      if_idx_reg  <= if_idx_next;
      cfg_reg     <= cfg_next;
      kind_reg    <= kind_next;
      armed_reg   <= armed_next;
      ok_reg      <= ok_next;
      greet_reg   <= greet_next;
      temp_en_reg <= temp_en_next;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  logic pull_reg;
  logic rtc_reg;
  logic io_reg;
  logic oe_reg;
  logic crst_reg;
  logic rdy_reg;
  logic save_reg;
  logic det_reg;
  logic pull_next;
  logic rtc_next;
  logic io_next;
  logic oe_next;
  logic crst_next;
  logic rdy_next;
  logic save_next;
  logic det_next;
  logic on_next;

  always_comb begin
    on_next   = state_next inside {ST_CORE_RESET, ST_CONFIG, ST_READY, ST_SAVE, ST_DETACH};
    pull_next = supply_valid;
    rtc_next  = supply_valid;
    io_next   = on_next;
    oe_next   = on_next && state_next != ST_CORE_RESET;
    crst_next = on_next && state_next != ST_CORE_RESET;
    rdy_next  = state_next == ST_READY;
    save_next = state_next == ST_SAVE;
    det_next  = state_next == ST_DETACH;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pull_reg <= 1'b0;
      rtc_reg  <= 1'b0;
      io_reg   <= 1'b0;
      oe_reg   <= 1'b0;
      crst_reg <= 1'b0;
      rdy_reg  <= 1'b0;
      save_reg <= 1'b0;
      det_reg  <= 1'b0;
    end else begin
      pull_reg <= pull_next;
      rtc_reg  <= rtc_next;
      io_reg   <= io_next;
      oe_reg   <= oe_next;
      crst_reg <= crst_next;
      rdy_reg  <= rdy_next;
      save_reg <= save_next;
      det_reg  <= det_next;
    end
  end

  assign pullup_en         = pull_reg;
  assign rtc_supply_output = rtc_reg;
  assign io_supply_en      = io_reg;
  assign pins_oe_allow     = oe_reg;
  assign core_reset_n      = crst_reg;
  assign iface_cfg_en      = cfg_reg;
  assign ready             = rdy_reg;
  assign greeting_send     = greet_reg;
  assign nv_net            = '{save_req: save_reg, detach_req: det_reg, reply_ok: ok_reg};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_pins_need_io: assert property (pins_oe_allow |-> io_supply_en)
    else $error("pins enabled without IO supply");
  a_rtc_follows_vcc: assert property (supply_valid |=> rtc_supply_output)
    else $error("RTC supply not enabled");
  a_ready_all_cfg: assert property ($rose(ready) |-> &iface_cfg_en)
    else $error("ready before all interfaces configured");
  a_greet_fixed: assert property (greeting_send |-> $past(fixed_baud))
    else $error("greeting without fixed baud");
  a_loss_off: assert property (!supply_valid |=> !io_supply_en && !nv_net.save_req)
    else $error("supply loss did not shut down");
  a_hold_reset: assert property (state_reg == ST_RESET_HOLD && !ext_reset_n |=> !io_supply_en)
    else $error("start not deferred by reset");
  a_save_first: assert property ($rose(nv_net.detach_req) |-> $past(nv_net.save_req))
    else $error("detach without save");
  a_hw_reset: assert property (reset_q && supply_valid && state_reg == ST_READY |=> !ready)
    else $error("reset pulse ignored");
  a_wake_off: assert property (state_reg == ST_POWER_OFF && supply_valid && rtc_alarm
                               && !(temp_en_reg && temp_danger) |=> io_supply_en)
    else $error("wake event ignored");

  c_ready:    cover property ($rose(ready));
  c_poweroff: cover property (state_reg == ST_DETACH ##1 state_reg == ST_POWER_OFF);
  c_halt:     cover property (state_reg == ST_HALT);
  c_wake:     cover property (state_reg == ST_POWER_OFF ##1 state_reg == ST_CORE_RESET);
endmodule

//--- tb/env_responder.sv
/*
  Far-side responder: settings store, network detach and interface setup.
  Assumes the sequencer holds each request level until it is answered.
*/
module env_responder #(
  parameter int NUM_IF = 4
) (
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire logic [7:0]        dly,
  input  wire logic              save_req,
  input  wire logic              detach_req,
  input  wire logic [NUM_IF-1:0] iface_cfg_en,
  output logic                   nv_done,
  output logic                   detach_done,
  output logic [NUM_IF-1:0]      iface_done
);
  // ----------------------------------------
  // Answer timing
  // ----------------------------------------
  // One request pends at a time; a dropped request clears its answer,
  // so a stale done never completes the next phase early
  logic [7:0] wait_cnt;
  logic       pending;
  logic       late;
  assign pending = (save_req && !nv_done) || (detach_req && !detach_done) ||
                   ((iface_cfg_en & ~iface_done) != '0);
  assign late = (wait_cnt >= dly);
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wait_cnt <= 8'h00;
      nv_done <= 1'b0;
      detach_done <= 1'b0;
      iface_done <= '0;
    end else begin
      wait_cnt <= pending ? wait_cnt + 8'h01 : 8'h00;
      nv_done <= save_req && (nv_done || late);
      detach_done <= detach_req && (detach_done || late);
      iface_done <= iface_cfg_en & (iface_done | {NUM_IF{late}});
    end
  end
endmodule

//--- tb/module_power_sequencer_test.sv
/*
  Self-checking bench for the module power sequencer.
  Assumes the package, the design and env_responder are compiled first.
*/
module module_power_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  import power_seq_pkg::*;
  localparam int NIF = 4;
  localparam int PMIN = 4;
  localparam int RMIN = 12;
  // ----------------------------------------
  // Signals and counters
  // ----------------------------------------
  logic sys_clk = 1'b0, nrst = 1'b0, supply_valid = 1'b0, supply_low_start = 1'b1;
  logic power_on_request_n = 1'b1, ext_reset_n = 1'b1, rtc_alarm = 1'b0, mini_card = 1'b0;
  logic fixed_baud = 1'b0, greeting_en = 1'b1, temperature_supervisor_cmd = 1'b0, temp_danger = 1'b0;
  host_cmd_t host_cmd = '0;
  logic [7:0] dly = 8'h00;
  nv_net_t nv_net;
  logic pullup_en, rtc_supply_output, io_supply_en, pins_oe_allow, core_reset_n, ready, greeting_send;
  logic nv_done, detach_done, p_save = 1'b0, p_det = 1'b0;
  logic [NIF-1:0] iface_cfg_en, iface_done;
  int bad_count = 0, total_checks = 0, cyc = 0, n_save = 0, n_det = 0, n_ok = 0, n_greet = 0;

  always #5 sys_clk = ~sys_clk;

  module_power_sequencer #(.PWRON_MIN_CYC(PMIN), .RESET_MIN_CYC(RMIN), .NUM_IF(NIF)) i_dut (
    .sys_clk, .nrst, .supply_valid, .supply_low_start, .power_on_request_n, .ext_reset_n,
    .rtc_alarm, .mini_card, .fixed_baud, .greeting_en, .temperature_supervisor_cmd,
    .temp_danger, .host_cmd, .nv_done, .detach_done, .iface_done, .nv_net, .pullup_en,
    .rtc_supply_output, .io_supply_en, .pins_oe_allow, .core_reset_n, .iface_cfg_en,
    .ready, .greeting_send);
  env_responder #(.NUM_IF(NIF)) i_env (.sys_clk, .nrst, .dly, .save_req(nv_net.save_req),
    .detach_req(nv_net.detach_req), .iface_cfg_en, .nv_done, .detach_done, .iface_done);

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic wait_lvl(bit io, logic lvl);
    for (int n = 0; n < 500 && (io ? io_supply_en : ready) !== lvl; n++) @(negedge sys_clk);
  endtask
  task automatic send(cmd_kind_t k);
    host_cmd = '{1'b1, k};
    tick(1);
    host_cmd = '0;
  endtask

  // Phase counters, plus ordering watchdogs checked every cycle
  always @(posedge sys_clk) begin
    cyc++;
    p_save <= nv_net.save_req;
    p_det <= nv_net.detach_req;
    if (nv_net.save_req === 1'b1 && !p_save) n_save++;
    if (nv_net.detach_req === 1'b1 && !p_det) n_det++;
    if (nv_net.reply_ok === 1'b1) n_ok++;
    if (greeting_send === 1'b1) n_greet++;
    if (pins_oe_allow === 1'b1) check("pins before io supply", 1, io_supply_en);
    if (ready === 1'b1) check("ready before setup", 1, &iface_done);
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_boot(logic fb);
    int g0;
    g0 = n_greet;
    fixed_baud = fb;
    ext_reset_n = 1'b0;
    power_on_request_n = 1'b0;
    supply_valid = 1'b1;
    supply_low_start = 1'b0;
    tick(2);
    check("pullup", 1, pullup_en);
    check("rtc supply", 1, rtc_supply_output);
    tick(6);
    check("held by reset", 0, io_supply_en | core_reset_n);
    power_on_request_n = 1'b1;
    ext_reset_n = 1'b1;
    tick(15);
    check("core reset", 0, core_reset_n);
    wait_lvl(0, 1);
    check("ready", 1, ready);
    check("setup", {NIF{1'b1}}, iface_cfg_en);
    // The pulse counter lags the output by one edge
    tick(1);
    check("greeting", fb, n_greet - g0);
  endtask
  task automatic t_off();
    int s0, d0, k0;
    s0 = n_save;
    d0 = n_det;
    k0 = n_ok;
    send(CMD_POWER_OFF);
    wait_lvl(1, 0);
    tick(2);
    check("saved", 1, n_save - s0);
    check("detached", 1, n_det - d0);
    check("reply", 1, n_ok - k0);
    check("pins off", 0, pins_oe_allow | ready);
    check("rtc kept", 1, rtc_supply_output);
    send(CMD_SW_RESET);
    tick(20);
    check("stays off", 0, io_supply_en | ready | (n_save - s0 - 1));
  endtask
  task automatic t_wake(int src);
    if (src == 0) begin
      power_on_request_n = 1'b0;
      tick(PMIN - 1);
      power_on_request_n = 1'b1;
      tick(10);
      check("short request", 0, io_supply_en | ready);
      power_on_request_n = 1'b0;
      tick(PMIN + 2);
      power_on_request_n = 1'b1;
    end else if (src == 1) begin
      ext_reset_n = 1'b0;
      tick(RMIN + 2);
      ext_reset_n = 1'b1;
    end else begin
      rtc_alarm = 1'b1;
      tick(1);
      rtc_alarm = 1'b0;
    end
    wait_lvl(0, 1);
    check("woken", 1, ready);
  endtask
  task automatic t_reboot(cmd_kind_t k, logic mc);
    int s0, d0;
    s0 = n_save;
    d0 = n_det;
    mini_card = mc;
    send(k);
    wait_lvl(0, 0);
    wait_lvl(0, 1);
    check("reboot ready", 1, ready);
    check("reboot save", 1, n_save - s0);
    check("reboot detach", 1, n_det - d0);
    mini_card = 1'b0;
  endtask
  task automatic t_hard(logic mc);
    int s0;
    s0 = n_save;
    mini_card = mc;
    ext_reset_n = 1'b0;
    tick(RMIN + 2);
    ext_reset_n = 1'b1;
    tick(2);
    // Mini-card reboots (IO supply stays on), solder-down shuts down
    check("hard off", 0, ready | (io_supply_en ^ mc));
    if (mc) wait_lvl(0, 1);
    check("hard back", mc, ready);
    check("hard no save", 0, n_save - s0);
    mini_card = 1'b0;
  endtask
  task automatic t_temp();
    temp_danger = 1'b1;
    tick(10);
    check("danger unwatched", 1, ready);
    temperature_supervisor_cmd = 1'b1;
    tick(5);
    check("danger off", 0, ready | io_supply_en);
    temp_danger = 1'b0;
    temperature_supervisor_cmd = 1'b0;
  endtask
  task automatic t_halt();
    int s0, k0;
    s0 = n_save;
    k0 = n_ok;
    send(CMD_HALT);
    for (int n = 0; n < 300 && n_ok == k0; n++) tick(1);
    tick(30);
    check("halt reply", 1, n_ok - k0);
    check("halt save", 1, n_save - s0);
    check("halted", 0, ready);
  endtask
  task automatic t_loss();
    int s0;
    s0 = n_save;
    supply_valid = 1'b0;
    supply_low_start = 1'b1;
    tick(2);
    check("loss", 0, io_supply_en | core_reset_n | pins_oe_allow | ready);
    check("loss rtc", 0, rtc_supply_output | pullup_en);
    check("loss no save", 0, n_save - s0);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    tick(2);
    nrst = 1'b1;
    tick(1);
    t_boot(1'b0);
    t_loss();
    dly = 8'h06;
    t_boot(1'b1);
    t_reboot(CMD_SW_RESET, 1'b0);
    t_reboot(CMD_POWER_OFF, 1'b1);
    for (int s = 0; s < 3; s++) begin
      t_off();
      t_wake(s);
    end
    t_hard(1'b1);
    t_hard(1'b0);
    t_wake(0);
    t_temp();
    t_wake(2);
    t_halt();
    t_loss();
    report_and_stop();
  end
endmodule
